// file: dv/sent_far_end.sv
`timescale 1ns/1ps
module sent_far_end (
  input wire logic clk,
  input wire logic lineFromDut,
  input wire logic oeN,
  output logic lineToDut
);
  // Intervals between falls seen on the line from the block, in clock cycles.
  int intv[$];
  int gap = 0;
  int cyc = 0;
  int lastFall = -100000;
  int tickCyc = 10;
  logic prevLine = 1'b1;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prevLine <= lineFromDut;
    gap <= gap + 1;
    if (prevLine && !lineFromDut && !oeN) begin
      intv.push_back(gap);
      gap <= 1;
    end
    lineToDut <= (cyc - lastFall) >= 5 * tickCyc;
  end
  // Each entry of t is an interval in ticks ending on a fall; a long idle opens with a fall.
  task automatic sendFrame(input int tick, input int t[$]);
    int i;
    @(negedge clk);
    tickCyc = tick;
    if (cyc - lastFall > 60 * tick) lastFall = cyc;
    for (i = 0; i < t.size(); i++) begin
      while (cyc - lastFall < t[i] * tick) @(negedge clk);
      lastFall = cyc;
    end
  endtask
endmodule

// file: dv/sent_nibble_link_bench.sv
`timescale 1ns/1ps
module sent_nibble_link_bench
  import sent_pkg::*;
;
  logic clk = 0, rstn = 0, enable = 0, rcvEnable = 0, txTriggerMode = 0, idleLevelSel = 0;
  logic crcEnable = 0, pauseEnable = 0, txLoad = 0, txTrigger = 0, sentIn;
  logic [2:0] nibbleCountSel = 3'h1;
  logic [15:0] tickPeriodCount = 16'h0003, frameTimeTicks = 16'h0000;
  logic [15:0] syncLowLimit = 16'h01c0, syncHighLimit = 16'h02a0;
  logic [3:0] txStatus = 4'h0, txCrc = 4'h0, rxStatus, rxCrc;
  logic [23:0] txData = 24'h000000, rxData;
  logic [15:0] rxSyncCount;
  logic sentOut, sentOeN, txBusy, txFrameDone, rxFrameDone, rxFramingError, rxCrcError;
  logic tickRangeError, nibbleCountError;
  int fails = 0, num_checks = 0, cyc = 0, doneCnt = 0, crcErrCnt = 0, frmErrCnt = 0, txDoneCnt = 0;
  int base, k, k0, e0;
  logic [15:0] tv[4] = '{16'h0094, 16'h0095, 16'h1193, 16'h1194};
  logic [2:0] nv[4] = '{3'h0, 3'h1, 3'h6, 3'h7};
  sent_nibble_link i_sent_nibble_link (.clk(clk), .rstn(rstn), .enable(enable),
    .rcvEnable(rcvEnable), .txTriggerMode(txTriggerMode), .idleLevelSel(idleLevelSel),
    .crcEnable(crcEnable), .pauseEnable(pauseEnable), .nibbleCountSel(nibbleCountSel),
    .tickPeriodCount(tickPeriodCount), .frameTimeTicks(frameTimeTicks),
    .syncLowLimit(syncLowLimit), .syncHighLimit(syncHighLimit), .txStatus(txStatus),
    .txData(txData), .txCrc(txCrc), .txLoad(txLoad), .txTrigger(txTrigger), .sentIn(sentIn),
    .sentOut(sentOut), .sentOeN(sentOeN), .txBusy(txBusy), .txFrameDone(txFrameDone),
    .rxStatus(rxStatus), .rxData(rxData), .rxCrc(rxCrc), .rxSyncCount(rxSyncCount),
    .rxFrameDone(rxFrameDone), .rxFramingError(rxFramingError), .rxCrcError(rxCrcError),
    .tickRangeError(tickRangeError), .nibbleCountError(nibbleCountError));
  sent_far_end i_sent_far_end (.clk(clk), .lineFromDut(sentOut), .oeN(sentOeN),
    .lineToDut(sentIn));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (rxFrameDone === 1'b1) doneCnt++;
    if (rxCrcError === 1'b1) crcErrCnt++;
    if (rxFramingError === 1'b1) frmErrCnt++;
    if (txFrameDone === 1'b1) txDoneCnt++;
    if (cyc == 60000) begin
      fails++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Checksum over the data nibbles, first nibble in the top bits, then one zero step.
  function automatic logic [3:0] crcOf(input logic [23:0] d, input int n);
    logic [4:0] c;
    int i, b;
    c = {1'b0, CRC_SEED};
    for (i = 0; i <= n; i++) begin
      for (b = 0; b < 4; b++) begin
        c = c << 1;
        if (c[4]) c = c ^ CRC_POLY;
      end
      if (i < n) c[3:0] = c[3:0] ^ d[23 - 4 * i -: 4];
    end
    return c[3:0];
  endfunction
  // Transmits in continuous mode with 4-cycle ticks and compares every interval.
  task automatic txRun(input logic [3:0] st, input logic [23:0] d, input int n,
      input logic hw, input logic [3:0] sw, input logic pz, input int ft);
    int exp[$];
    int used, p, i;
    logic [3:0] cv;
    cv = hw ? crcOf(d, n) : sw;
    exp = {int'(SYNC_TICKS), int'(NIB_BASE) + st};
    for (i = 0; i < n; i++) exp.push_back(int'(NIB_BASE) + d[23 - 4 * i -: 4]);
    exp.push_back(int'(NIB_BASE) + cv);
    used = exp.sum();
    p = (ft > 2047 ? 2047 : ft) - used;
    if (p < int'(PAUSE_MIN)) p = int'(PAUSE_MIN);
    if (p > int'(PAUSE_MAX)) p = int'(PAUSE_MAX);
    if (pz) exp.push_back(p);
    exp.push_back(int'(SYNC_TICKS));
    @(posedge clk);
    {txStatus, txData, txCrc, crcEnable, pauseEnable} <= {st, d, sw, hw, pz};
    nibbleCountSel <= n[2:0];
    frameTimeTicks <= ft[15:0];
    txLoad <= 1'b1;
    @(posedge clk);
    txLoad <= 1'b0;
    enable <= 1'b1;
    base = i_sent_far_end.intv.size();
    for (k = 0; k < 20000 && i_sent_far_end.intv.size() <= base + exp.size(); k++) @(posedge clk);
    for (i = 0; i < exp.size(); i++) begin
      check("tx interval", exp[i] * 4, i_sent_far_end.intv[base + 1 + i]);
    end
    @(posedge clk) enable <= 1'b0;
  endtask
  task automatic rxRun(input int tick, input logic [3:0] st, input logic [23:0] d, input int n,
      input logic [3:0] flip);
    int t[$];
    int i, d0, c0;
    logic [3:0] cv;
    cv = crcOf(d, n) ^ flip;
    t = {int'(SYNC_TICKS), int'(NIB_BASE) + st};
    for (i = 0; i < n; i++) t.push_back(int'(NIB_BASE) + d[23 - 4 * i -: 4]);
    t.push_back(int'(NIB_BASE) + cv);
    @(posedge clk) nibbleCountSel <= n[2:0];
    d0 = doneCnt;
    c0 = crcErrCnt;
    i_sent_far_end.sendFrame(tick, t);
    repeat (10) @(posedge clk);
    check("rx done", d0 + 1, doneCnt);
    check("rx status", {28'h0, st}, rxStatus);
    check("rx data", d & ~(24'hffffff >> (4 * n)), rxData);
    check("rx crc", {28'h0, cv}, rxCrc);
    check("rx sync", 56 * tick, rxSyncCount);
    check("rx crc error", c0 + (flip != 4'h0 && crcEnable), crcErrCnt);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    check("reset line", 3'h6, {sentOut, sentOeN, txBusy});
    for (k = 0; k < 4; k++) begin
      @(posedge clk) {tickPeriodCount, nibbleCountSel} <= {tv[k], nv[k]};
      repeat (5) @(posedge clk);
      check("tick range", (k == 0 || k == 3), tickRangeError);
      check("nibble count", (k == 0 || k == 3), nibbleCountError);
    end
    @(posedge clk) tickPeriodCount <= 16'h0003;
    txRun(4'ha, 24'h123456, 6, 1'b1, 4'h0, 1'b0, 0);
    txRun(4'h0, 24'hf00000, 1, 1'b0, 4'h7, 1'b1, 0);
    txRun(4'hf, 24'h0f0000, 2, 1'b0, 4'h0, 1'b1, 200);
    @(posedge clk) {txTriggerMode, pauseEnable, enable} <= 3'b101;
    repeat (200) @(posedge clk);
    check("trigger wait", 0, txBusy);
    k0 = txDoneCnt;
    @(posedge clk) txTrigger <= 1'b1;
    @(posedge clk) txTrigger <= 1'b0;
    for (k = 0; k < 2000 && txDoneCnt == k0; k++) @(posedge clk);
    repeat (3) @(posedge clk);
    base = i_sent_far_end.intv.size();
    repeat (400) @(posedge clk);
    check("trigger frames", k0 + 1, txDoneCnt);
    check("trigger quiet", base, i_sent_far_end.intv.size());
    @(posedge clk) {enable, txTriggerMode, idleLevelSel} <= 3'b001;
    repeat (4) @(posedge clk);
    check("idle low", 1, {sentOut, sentOeN});
    @(posedge clk) idleLevelSel <= 1'b0;
    repeat (4) @(posedge clk);
    check("idle high", 3, {sentOut, sentOeN});
    @(posedge clk) {rcvEnable, crcEnable, enable} <= 3'b111;
    repeat (5) @(posedge clk);
    rxRun(10, 4'h3, 24'habcdef, 6, 4'h0);
    rxRun(12, 4'hc, 24'h5a0000, 2, 4'h0);
    rxRun(8, 4'h0, 24'hf00000, 1, 4'h1);
    e0 = frmErrCnt;
    k0 = doneCnt;
    i_sent_far_end.sendFrame(10, '{56, 30});
    i_sent_far_end.sendFrame(10, '{70});
    repeat (10) @(posedge clk);
    check("rx framing", e0 + 2, frmErrCnt);
    check("rx no frame", k0, doneCnt);
    rxRun(10, 4'h9, 24'h100000, 1, 4'h0);
    @(posedge clk) {crcEnable, pauseEnable} <= 2'b01;
    rxRun(10, 4'h1, 24'h800000, 1, 4'h2);
    e0 = frmErrCnt;
    i_sent_far_end.sendFrame(10, '{20});
    rxRun(10, 4'h2, 24'h300000, 1, 4'h0);
    i_sent_far_end.sendFrame(10, '{11});
    repeat (10) @(posedge clk);
    check("rx pause", e0 + 1, frmErrCnt);
    conclude();
  end
endmodule

// file: dv/sent_nibble_link_checker.sv
`timescale 1ns/1ps
module sent_nibble_link_checker
  import sent_pkg::*;
#(
  parameter int TICK_MAX_CYCLES = TICK_MAX_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic rcvEnable,
  input wire logic txTriggerMode,
  input wire logic idleLevelSel,
  input wire logic [2:0] nibbleCountSel,
  input wire logic [15:0] tickPeriodCount,
  input wire logic [15:0] syncLowLimit,
  input wire logic [15:0] syncHighLimit,
  input wire logic txTrigger,
  input wire logic sentOut,
  input wire logic sentOeN,
  input wire logic txBusy,
  input wire logic txFrameDone,
  input wire logic [3:0] rxStatus,
  input wire logic [23:0] rxData,
  input wire logic [15:0] rxSyncCount,
  input wire logic rxFrameDone,
  input wire logic rxCrcError,
  input wire logic tickRangeError,
  input wire logic nibbleCountError
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Cycles since reset release, so that checks skip the internal reset flops.
  logic [2:0] age_q;
  logic [2:0] age_d;
  logic settled;
  assign settled = (age_q == 3'h7);
  always_comb begin
    age_d = settled ? age_q : age_q + 3'h1;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      age_q <= 3'h0;
    end else begin
      age_q <= age_d;
    end
  end
  sequence txHeld;
    (enable && !rcvEnable) [*2];
  endsequence
  sequence doneThenQuiet;
    (txTriggerMode && !txTrigger) throughout (txFrameDone ##1 1'b1 [*3]);
  endsequence
  chk_tx_drive: assert property (txHeld ##0 settled |-> !sentOeN)
    else $error("output enable not active in transmit");
  chk_rx_release: assert property (rcvEnable [*2] |-> sentOeN && !txBusy)
    else $error("transmitter active in receive");
  chk_idle_level: assert property ((!enable && $stable(idleLevelSel)) [*3] ##0 settled
    |-> sentOut == !idleLevelSel && sentOeN)
    else $error("wrong idle level");
  chk_done_busy: assert property (txFrameDone |-> $past(txBusy))
    else $error("frame done without frame");
  chk_trig_quiet: assert property (doneThenQuiet |-> !txBusy)
    else $error("frame started without trigger");
  chk_tick_range: assert property ($stable(tickPeriodCount) [*3] ##0 settled
    |-> tickRangeError == ((int'(tickPeriodCount) + 1 < TICK_MIN_CYC) ||
    (int'(tickPeriodCount) + 1 > TICK_MAX_CYCLES)))
    else $error("tick range flag wrong");
  chk_count_flag: assert property ($stable(nibbleCountSel) [*3] ##0 settled
    |-> nibbleCountError == (nibbleCountSel < NIBBLE_COUNT_SEL_MIN || nibbleCountSel > NIBBLE_COUNT_SEL_MAX))
    else $error("nibble count flag wrong");
  chk_crc_pair: assert property (rxCrcError |-> rxFrameDone)
    else $error("checksum error outside frame end");
  chk_rx_hold: assert property (!rxFrameDone
    |-> $stable(rxData) && $stable(rxStatus) && $stable(rxSyncCount))
    else $error("receive buffer changed between frames");
  chk_sync_window: assert property (rxFrameDone
    |-> rxSyncCount >= syncLowLimit && rxSyncCount <= syncHighLimit)
    else $error("frame accepted outside sync window");
endmodule
bind sent_nibble_link sent_nibble_link_checker #(.TICK_MAX_CYCLES(TICK_MAX_CYCLES)) i_checker (
  .clk(clk), .rstn(rstn), .enable(enable), .rcvEnable(rcvEnable),
  .txTriggerMode(txTriggerMode), .idleLevelSel(idleLevelSel),
  .nibbleCountSel(nibbleCountSel), .tickPeriodCount(tickPeriodCount),
  .syncLowLimit(syncLowLimit), .syncHighLimit(syncHighLimit), .txTrigger(txTrigger),
  .sentOut(sentOut), .sentOeN(sentOeN), .txBusy(txBusy), .txFrameDone(txFrameDone),
  .rxStatus(rxStatus), .rxData(rxData), .rxSyncCount(rxSyncCount),
  .rxFrameDone(rxFrameDone), .rxCrcError(rxCrcError), .tickRangeError(tickRangeError),
  .nibbleCountError(nibbleCountError));

// file: rtl/sent_nibble_link.sv
`timescale 1ns/1ps
// Contract
// - One-way single wire; intervals run from falling edge to falling edge.
// - Both ends share a preset tick period between 3 and 90 us.
// - Each frame opens with a sync interval of 56 ticks.
// - Receiver derives tick length from measured sync and decodes that frame.
// - Receiver tolerates tick deviation up to 20 percent from nominal.
// - A nibble lasts its value plus 12 ticks, 12 to 27 ticks.
// - One status nibble follows the sync interval.
// - One to six data nibbles follow the status nibble.
// - One checksum nibble follows the last data nibble.
// - With pause enabled, a 12 to 768 tick pause ends the frame.
// - Block is a transmitter after reset unless receive is selected.
// - Transmit runs continuously while enabled, or one frame per trigger.
// - Transmit order: sync, nibbles, checksum, then pause when enabled.
// - Transmit tick period comes from a 16-bit count setting.
// - Status, data and checksum of one frame are buffered.
// - Receiver flags intervals outside legal nibble or sync ranges.
// - Receiver optionally checks the checksum nibble and flags mismatch.
// - Transmitter computes checksum in hardware or sends the supplied one.
// - Nibble count codes 1 to 6 are valid; 0 and 7 are reserved.
// - Idle-level setting chooses the resting level of the transmit output.
// - Transmitter never makes a pause shorter than 12 ticks.
// - Receiver starts a frame only on an interval inside the sync limits.
module sent_nibble_link
  import sent_pkg::*;
#(
  parameter int TICK_MAX_CYCLES = TICK_MAX_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic rcvEnable,
  input wire logic txTriggerMode,
  input wire logic idleLevelSel,
  input wire logic crcEnable,
  input wire logic pauseEnable,
  input wire logic [2:0] nibbleCountSel,
  input wire logic [15:0] tickPeriodCount,
  input wire logic [15:0] frameTimeTicks,
  input wire logic [15:0] syncLowLimit,
  input wire logic [15:0] syncHighLimit,
  input wire logic [3:0] txStatus,
  input wire logic [23:0] txData,
  input wire logic [3:0] txCrc,
  input wire logic txLoad,
  input wire logic txTrigger,
  input wire logic sentIn,
  output logic sentOut,
  output logic sentOeN,
  output logic txBusy,
  output logic txFrameDone,
  output logic [3:0] rxStatus,
  output logic [23:0] rxData,
  output logic [3:0] rxCrc,
  output logic [15:0] rxSyncCount,
  output logic rxFrameDone,
  output logic rxFramingError,
  output logic rxCrcError,
  output logic tickRangeError,
  output logic nibbleCountError
);

  typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_NIB, TX_PAUSE} tx_state_t;
  typedef enum logic [1:0] {RX_HUNT, RX_NIB, RX_PAUSE} rx_state_t;

  // One step of the checksum: multiply by x^4 modulo the polynomial, then add the nibble.
  function automatic logic [3:0] crcStep(input logic [3:0] crc, input logic [3:0] nib);
    logic [7:0] v;
    v = {crc, 4'h0};
    for (int i = 7; i >= 4; i--) begin
      if (v[i]) begin
        v = v ^ 8'({3'h0, CRC_POLY} << (i - 4));
      end
    end
    return v[3:0] ^ nib;
  endfunction

  function automatic logic [3:0] nibOf(input logic [23:0] data, input int k);
    return 4'(data >> (20 - 4 * k));
  endfunction

  function automatic logic [3:0] crcFrame(input logic [23:0] data, input logic [2:0] n);
    logic [3:0] crc;
    crc = CRC_SEED;
    for (int k = 0; k < MAX_NIBBLES; k++) begin
      if (k < int'(n)) begin
        crc = crcStep(crc, nibOf(data, k));
      end
    end
    return crcStep(crc, 4'h0);
  endfunction

  // Reserved count codes fall back to the nearest legal count.
  function automatic logic [2:0] nibCount(input logic [2:0] sel);
    if (sel < NIBBLE_COUNT_SEL_MIN) begin
      return NIBBLE_COUNT_SEL_MIN;
    end
    if (sel > NIBBLE_COUNT_SEL_MAX) begin
      return NIBBLE_COUNT_SEL_MAX;
    end
    return sel;
  endfunction

  logic [1:0] rstSync_q;
  logic rstnInt;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstnInt = rstSync_q[1];

  logic [2:0] nEff;
  logic txOn;
  logic rxOn;
  assign nEff = nibCount(nibbleCountSel);
  assign txOn = enable & ~rcvEnable;
  assign rxOn = enable & rcvEnable;

  // Tick generator and configuration checks.
  logic [15:0] tickDiv_q, tickDiv_d;
  logic tickEn_q, tickEn_d;
  logic tickRangeError_d, nibbleCountError_d;
  logic [16:0] tickCycles;
  assign tickCycles = {1'b0, tickPeriodCount} + 17'h00001;

  always_comb begin
    tickDiv_d = tickDiv_q + 16'h0001;
    tickEn_d = 1'b0;
    if (!txOn) begin
      tickDiv_d = 16'h0000;
    end else if (tickDiv_q >= tickPeriodCount) begin
      tickDiv_d = 16'h0000;
      tickEn_d = 1'b1;
    end
    tickRangeError_d = (tickCycles < 17'(TICK_MIN_CYC)) ||
                       (tickCycles > 17'(TICK_MAX_CYCLES));
    nibbleCountError_d = (nibbleCountSel < NIBBLE_COUNT_SEL_MIN) || (nibbleCountSel > NIBBLE_COUNT_SEL_MAX);
  end

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      tickDiv_q <= 16'h0000;
      tickEn_q <= 1'b0;
      tickRangeError <= 1'b0;
      nibbleCountError <= 1'b0;
    end else begin
      tickDiv_q <= tickDiv_d;
      tickEn_q <= tickEn_d;
      tickRangeError <= tickRangeError_d;
      nibbleCountError <= nibbleCountError_d;
    end
  end

  // Transmitter.
  tx_state_t txState_q, txState_d;
  logic [9:0] tickPos_q, tickPos_d;
  logic [9:0] intLen_q, intLen_d;
  logic [2:0] nibIdx_q, nibIdx_d;
  logic [11:0] frameTicks_q, frameTicks_d;
  logic [3:0] sStat_q, sStat_d, wStat_q, wStat_d;
  logic [23:0] sData_q, sData_d, wData_q, wData_d;
  logic [3:0] sCrc_q, sCrc_d, wCrc_q, wCrc_d;
  logic trigPend_q, trigPend_d;
  logic sentOut_d, sentOeN_d, txBusy_d, txFrameDone_d;
  logic wantStart, beginFrame, endFrame;
  logic [3:0] nextNib;
  logic [11:0] ftCap, used, remain;

  always_comb begin
    txState_d = txState_q;
    tickPos_d = tickPos_q;
    intLen_d = intLen_q;
    nibIdx_d = nibIdx_q;
    frameTicks_d = frameTicks_q;
    wStat_d = wStat_q;
    wData_d = wData_q;
    wCrc_d = wCrc_q;
    sStat_d = sStat_q;
    sData_d = sData_q;
    sCrc_d = sCrc_q;
    beginFrame = 1'b0;
    endFrame = 1'b0;
    nextNib = 4'h0;
    txFrameDone_d = 1'b0;
    ftCap = (frameTimeTicks > 16'(FRAME_TIME_CAP)) ? FRAME_TIME_CAP : frameTimeTicks[11:0];
    used = frameTicks_q + 12'h001;
    remain = ftCap - used;
    if (txLoad) begin
      sStat_d = txStatus;
      sData_d = txData;
      sCrc_d = txCrc;
    end
    wantStart = txOn & (~txTriggerMode | trigPend_q);
    if (!txOn) begin
      txState_d = TX_IDLE;
      tickPos_d = 10'h000;
    end else if (tickEn_q) begin
      if (txState_q == TX_IDLE) begin
        beginFrame = wantStart;
      end else begin
        tickPos_d = tickPos_q + 10'h001;
        frameTicks_d = used;
        if (tickPos_q + 10'h001 == intLen_q) begin
          tickPos_d = 10'h000;
          case (txState_q)
            TX_SYNC: begin
              txState_d = TX_NIB;
              nibIdx_d = 3'h0;
              intLen_d = NIB_BASE + 10'(wStat_q);
            end
            TX_NIB: begin
              if (nibIdx_q == nEff + 3'h1) begin
                if (pauseEnable) begin
                  txState_d = TX_PAUSE;
                  if (ftCap < used + 12'(PAUSE_MIN)) begin
                    intLen_d = PAUSE_MIN;
                  end else if (remain > 12'(PAUSE_MAX)) begin
                    intLen_d = PAUSE_MAX;
                  end else begin
                    intLen_d = remain[9:0];
                  end
                end else begin
                  endFrame = 1'b1;
                end
              end else begin
                nibIdx_d = nibIdx_q + 3'h1;
                if (nibIdx_d == nEff + 3'h1) begin
                  nextNib = crcEnable ? crcFrame(wData_q, nEff) : wCrc_q;
                end else begin
                  nextNib = nibOf(wData_q, int'(nibIdx_q));
                end
                intLen_d = NIB_BASE + 10'(nextNib);
              end
            end
            TX_PAUSE: begin
              endFrame = 1'b1;
            end
            default: begin
              txState_d = TX_IDLE;
            end
          endcase
        end
        if (endFrame) begin
          txFrameDone_d = 1'b1;
          txState_d = TX_IDLE;
          beginFrame = wantStart;
        end
      end
      if (beginFrame) begin
        txState_d = TX_SYNC;
        intLen_d = SYNC_TICKS;
        tickPos_d = 10'h000;
        frameTicks_d = 12'h000;
        wStat_d = sStat_q;
        wData_d = sData_q;
        wCrc_d = sCrc_q;
      end
    end
    trigPend_d = txTrigger | (trigPend_q & ~beginFrame);
    txBusy_d = txState_d != TX_IDLE;
    sentOut_d = ~(txBusy_d && (tickPos_d < LOW_TICKS)) ^ idleLevelSel;
    sentOeN_d = ~txOn;
  end

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      txState_q <= TX_IDLE;
      tickPos_q <= 10'h000;
      intLen_q <= SYNC_TICKS;
      nibIdx_q <= 3'h0;
      frameTicks_q <= 12'h000;
      sStat_q <= 4'h0;
      sData_q <= 24'h000000;
      sCrc_q <= 4'h0;
      wStat_q <= 4'h0;
      wData_q <= 24'h000000;
      wCrc_q <= 4'h0;
      trigPend_q <= 1'b0;
      sentOut <= 1'b1;
      sentOeN <= 1'b1;
      txBusy <= 1'b0;
      txFrameDone <= 1'b0;
    end else begin
      txState_q <= txState_d;
      tickPos_q <= tickPos_d;
      intLen_q <= intLen_d;
      nibIdx_q <= nibIdx_d;
      frameTicks_q <= frameTicks_d;
      sStat_q <= sStat_d;
      sData_q <= sData_d;
      sCrc_q <= sCrc_d;
      wStat_q <= wStat_d;
      wData_q <= wData_d;
      wCrc_q <= wCrc_d;
      trigPend_q <= trigPend_d;
      sentOut <= sentOut_d;
      sentOeN <= sentOeN_d;
      txBusy <= txBusy_d;
      txFrameDone <= txFrameDone_d;
    end
  end

  // Receiver. Ticks are counted by adding 56 per clock and removing one sync length per tick.
  logic [2:0] inSync_q;
  rx_state_t rxState_q, rxState_d;
  logic [15:0] cnt_q, cnt_d, syncCap_q, syncCap_d;
  logic [16:0] acc_q, acc_d, accSum;
  logic [9:0] ticks_q, ticks_d;
  logic [2:0] rIdx_q, rIdx_d;
  logic [3:0] rStat_q, rStat_d;
  logic [23:0] rData_q, rData_d;
  logic [3:0] rxStatus_d, rxCrc_d;
  logic [23:0] rxData_d;
  logic [15:0] rxSyncCount_d;
  logic rxFrameDone_d, rxFramingError_d, rxCrcError_d;
  logic fall, syncOk, nibOk;
  logic [3:0] nibVal;

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      inSync_q <= 3'h7;
    end else begin
      inSync_q <= {inSync_q[1:0], sentIn};
    end
  end

  always_comb begin
    rxState_d = rxState_q;
    syncCap_d = syncCap_q;
    rIdx_d = rIdx_q;
    rStat_d = rStat_q;
    rData_d = rData_q;
    rxStatus_d = rxStatus;
    rxData_d = rxData;
    rxCrc_d = rxCrc;
    rxSyncCount_d = rxSyncCount;
    rxFrameDone_d = 1'b0;
    rxFramingError_d = 1'b0;
    rxCrcError_d = 1'b0;
    fall = inSync_q[2] & ~inSync_q[1];
    syncOk = (cnt_q >= syncLowLimit) && (cnt_q <= syncHighLimit);
    nibOk = (ticks_q >= NIB_BASE) && (ticks_q <= NIB_LAST);
    nibVal = 4'(ticks_q - NIB_BASE);
    cnt_d = (cnt_q == 16'hffff) ? cnt_q : cnt_q + 16'h0001;
    accSum = acc_q + 17'(SYNC_TICKS);
    acc_d = accSum;
    ticks_d = ticks_q;
    if (accSum >= {1'b0, syncCap_q}) begin
      acc_d = accSum - {1'b0, syncCap_q};
      ticks_d = (ticks_q == 10'h3ff) ? ticks_q : ticks_q + 10'h001;
    end
    if (!rxOn) begin
      rxState_d = RX_HUNT;
    end else if (fall) begin
      cnt_d = 16'h0001;
      ticks_d = 10'h000;
      case (rxState_q)
        RX_NIB: begin
          if (!nibOk) begin
            rxFramingError_d = 1'b1;
            rxState_d = RX_HUNT;
          end else if (rIdx_q == 3'h0) begin
            rStat_d = nibVal;
            rIdx_d = 3'h1;
          end else if (rIdx_q <= nEff) begin
            for (int k = 0; k < MAX_NIBBLES; k++) begin
              if (k == int'(rIdx_q) - 1) begin
                rData_d[23 - 4 * k -: 4] = nibVal;
              end
            end
            if (rIdx_q < nEff) begin
              rData_d = rData_d & ~(24'hffffff >> (4 * int'(rIdx_q)));
            end
            rIdx_d = rIdx_q + 3'h1;
          end else begin
            rxStatus_d = rStat_q;
            rxData_d = rData_q;
            rxCrc_d = nibVal;
            rxSyncCount_d = syncCap_q;
            rxFrameDone_d = 1'b1;
            rxCrcError_d = crcEnable && (crcFrame(rData_q, nEff) != nibVal);
            rxState_d = pauseEnable ? RX_PAUSE : RX_HUNT;
          end
        end
        RX_PAUSE: begin
          if ((ticks_q < PAUSE_MIN) || (ticks_q > PAUSE_MAX)) begin
            rxFramingError_d = 1'b1;
          end
          rxState_d = RX_HUNT;
        end
        default: begin
          rxState_d = RX_HUNT;
        end
      endcase
      if ((rxState_q == RX_HUNT) || (rxFramingError_d && rxState_q == RX_NIB)) begin
        if (syncOk) begin
          rxState_d = RX_NIB;
          syncCap_d = cnt_q;
          rIdx_d = 3'h0;
          rData_d = 24'h000000;
        end else if (rxState_q == RX_HUNT && cnt_q != 16'hffff) begin
          rxFramingError_d = 1'b1;
        end
      end
      acc_d = {2'h0, syncCap_d[15:1]};
    end
  end

  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      rxState_q <= RX_HUNT;
      cnt_q <= 16'hffff;
      syncCap_q <= 16'hffff;
      acc_q <= 17'h00000;
      ticks_q <= 10'h000;
      rIdx_q <= 3'h0;
      rStat_q <= 4'h0;
      rData_q <= 24'h000000;
      rxStatus <= 4'h0;
      rxData <= 24'h000000;
      rxCrc <= 4'h0;
      rxSyncCount <= 16'h0000;
      rxFrameDone <= 1'b0;
      rxFramingError <= 1'b0;
      rxCrcError <= 1'b0;
    end else begin
      rxState_q <= rxState_d;
      cnt_q <= cnt_d;
      syncCap_q <= syncCap_d;
      acc_q <= acc_d;
      ticks_q <= ticks_d;
      rIdx_q <= rIdx_d;
      rStat_q <= rStat_d;
      rData_q <= rData_d;
      rxStatus <= rxStatus_d;
      rxData <= rxData_d;
      rxCrc <= rxCrc_d;
      rxSyncCount <= rxSyncCount_d;
      rxFrameDone <= rxFrameDone_d;
      rxFramingError <= rxFramingError_d;
      rxCrcError <= rxCrcError_d;
    end
  end

endmodule

// file: rtl/sent_pkg.sv
package sent_pkg;

  localparam int CLK_MHZ = 50;
  localparam int TICK_MIN_US = 3;
  localparam int TICK_MAX_US = 90;
  localparam int TICK_MIN_CYC = TICK_MIN_US * CLK_MHZ;
  localparam int TICK_MAX_CYC = TICK_MAX_US * CLK_MHZ;

  localparam logic [9:0] SYNC_TICKS = 10'd56;
  localparam logic [9:0] NIB_BASE = 10'd12;
  localparam logic [9:0] NIB_LAST = 10'd27;
  localparam logic [9:0] PAUSE_MIN = 10'd12;
  localparam logic [9:0] PAUSE_MAX = 10'd768;
  localparam logic [9:0] LOW_TICKS = 10'd5;
  localparam logic [11:0] FRAME_TIME_CAP = 12'd2047;

  localparam logic [2:0] NIBBLE_COUNT_SEL_MIN = 3'h1;
  localparam logic [2:0] NIBBLE_COUNT_SEL_MAX = 3'h6;
  localparam int MAX_NIBBLES = 6;

  localparam logic [3:0] CRC_SEED = 4'h5;
  localparam logic [4:0] CRC_POLY = 5'h1d;

  localparam logic [15:0] SYNC_HALF_SHIFT = 16'h0001;

endpackage
